/* bench/macs_link_monitor.sv */
// Concurrent checks on the converter serial link signals
`timescale 1ns/1ps
`default_nettype none
module macs_link_monitor (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic shift_clock,
    input wire logic serial_config_in,
    input wire logic serial_result_out,
    input wire logic result_out_oe_n,
    input wire logic conversion_start,
    input wire logic read_enable_n,
    input wire logic busy_n
);
    // ****************************************
    // Link checks, all sampled on pclk
    // ****************************************
    default clocking mcb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    oe_gate_a:
    assert property (result_out_oe_n == read_enable_n)
        else $error("output enable does not follow read enable");
    busy_start_a:
    assert property ($rose(conversion_start) |-> ##[1:5] !busy_n)
        else $error("busy did not fall after start");
    // Bounds assume the bench sets the conversion count to 20
    conv_len_a:
    assert property ($fell(busy_n) |-> !busy_n [*8] ##[8:20] busy_n)
        else $error("conversion length out of bounds");
    start_high_a:
    assert property ($rose(conversion_start) |-> conversion_start [*2])
        else $error("start pulse too short");
    start_idle_a:
    assert property ($rose(conversion_start) |-> busy_n)
        else $error("start raised while converting");
    sck_quiet_a:
    assert property (!busy_n |-> $stable(shift_clock))
        else $error("shift clock moved during conversion");
    sdi_hold_a:
    assert property ($rose(shift_clock) |-> $stable(serial_config_in))
        else $error("config bit changed at capture edge");
    // Result load near busy rising is excluded; only shifting is judged
    sdo_edge_a:
    assert property ($changed(serial_result_out) && !read_enable_n
        && busy_n && $past(busy_n, 4) |-> $fell(shift_clock))
        else $error("result bit changed off the falling edge");
    cover property ($rose(conversion_start));
    cover property ($rose(busy_n));
    cover property ($fell(read_enable_n) && busy_n);
    cover property (read_enable_n && !busy_n);
endmodule
`default_nettype wire

/* bench/mux_adc_conversion_serial_control_tb.sv */
// Testbench joining host and converter ends over the serial link
`timescale 1ns/1ps
`default_nettype none
module mux_adc_conversion_serial_control_tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [15:0] analog_code;
    logic [7:0] active_config;
    logic acquiring;
    int miscompares, checks, cycles, seed, bit_cnt;
    logic [15:0] rx;
    logic [7:0] cfg_seen;
    logic [15:0] exp_q[$];
    macs_link_if link();
    macs_host u_macs_host (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .link(link));
    macs_device #(.RES_BITS(16), .CONV_CYC(20)) u_macs_device (
        .pclk(pclk), .presetn(presetn), .link(link),
        .analog_code(analog_code), .active_config(active_config),
        .acquiring(acquiring));
    macs_link_monitor u_macs_link_monitor (.pclk(pclk),
        .presetn(presetn), .shift_clock(link.shift_clock),
        .serial_config_in(link.serial_config_in),
        .serial_result_out(link.serial_result_out),
        .result_out_oe_n(link.result_out_oe_n),
        .conversion_start(link.conversion_start),
        .read_enable_n(link.read_enable_n), .busy_n(link.busy_n));
    // ****************************************
    // Clock, timeout and wire capture
    // ****************************************
    initial begin
        pclk = 0;
        forever #10 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            tally_and_finish();
        end
    end
    // Wire view kept apart from the host registers to catch paired faults
    always @(posedge link.shift_clock or negedge presetn) begin
        if (!presetn) begin
            bit_cnt = 0;
        end else begin
            if (bit_cnt < 8) cfg_seen = {cfg_seen[6:0], link.serial_config_in};
            rx = {rx[14:0], link.result_wire};
            bit_cnt = (bit_cnt + 1) % 16;
        end
    end
    // ****************************************
    // Tasks
    // ****************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task automatic op(input logic [7:0] cfg, input logic tied,
        input logic twice);
        logic [31:0] r;
        logic e;
        logic [15:0] a;
        int n;
        a = 16'($random(seed));
        analog_code <= a;
        exp_q.push_back(a);
        apb(1, macs_pkg::REG_CTRL, {22'h0, tied, 1'b1, cfg}, r, e);
        // A second go while the link is busy must not take effect
        if (twice) apb(1, macs_pkg::REG_CTRL, {22'h0, tied, 1'b1, ~cfg}, r, e);
        n = 0;
        do begin
            apb(0, macs_pkg::REG_STATUS, 32'h0, r, e);
            n++;
        end while (n < 3 || r[macs_pkg::STAT_BUSY_POS] !== 1'b0);
        chk(r[macs_pkg::STAT_DONE_POS], 1'b1);
        apb(0, macs_pkg::REG_RESULT, 32'h0, r, e);
        chk(r[15:0], exp_q[0]);
        chk(e, 1'b0);
        chk(rx, exp_q.pop_front());
        chk(cfg_seen, cfg);
        chk(active_config, cfg);
        chk(acquiring, 1'b0);
    endtask
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        logic [31:0] r;
        logic e;
        seed = 71665;
        presetn = 0;
        psel = 0;
        penable = 0;
        pwrite = 0;
        paddr = 8'h00;
        pwdata = 32'h0;
        analog_code = 16'h0000;
        exp_q.push_back(macs_pkg::RESULT_RESET);
        repeat (3) @(posedge pclk);
        presetn <= 1;
        apb(0, macs_pkg::REG_STATUS, 32'h0, r, e);
        chk(r[1:0], 2'b00);
        chk(link.busy_n, 1'b1);
        apb(0, 8'h10, 32'h0, r, e);
        chk(e, 1'b1);
        // Sleep bit kept clear: waking needs a sequence outside this block
        for (int i = 0; i < 10; i++) begin
            op(8'($random(seed)) & 8'hfe, i[0], i == 3);
        end
        tally_and_finish();
    end
endmodule
`default_nettype wire

/* core/macs_device.sv */
// Converter end: configuration capture, conversion timing, result shifting
//
// Added by the designer: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Eight config bits on first rising edges
// - Acquire from sixth fall until start
// - Host waits 4us before conversion start
// - Running conversion cannot be restarted
// - MSB-first approximation, load 16-bit result
// - Unipolar offset binary, bipolar two's complement
// - Internal timer sets 4us conversion
// - Host holds start high 40ns; host here holds it 60ns, or until busy rises in tied mode
// - Busy low while converting
// - Narrow variants drive trailing zeros
// - Read enable low keeps output on
// - Tied start and read: rise starts
// - Tied mode: output off while converting
// - Send on falling, capture on rising
// - Fixed field order; extra bits ignored
// - Read enable gates output and input
module macs_device #(
    parameter int RES_BITS = 16,
    parameter int CONV_CYC = macs_pkg::CONV_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    macs_link_if.device link,
    input wire logic [15:0] analog_code,
    output logic [7:0] active_config,
    output logic acquiring
);
    // ****************************************
    // Link side: input shift on rising edges
    // ****************************************
    logic [7:0] cfg_shift;
    logic [4:0] rise_count;
    logic [7:0] cfg_word;
    logic cfg_toggle;
    always_ff @(posedge link.shift_clock or negedge presetn) begin
        if (!presetn) begin
            cfg_shift <= macs_pkg::CFG_RESET;
            rise_count <= 5'h00;
            cfg_word <= macs_pkg::CFG_RESET;
            cfg_toggle <= 1'b0;
        end else if (!link.read_enable_n) begin
            if (rise_count < 5'(macs_pkg::CFG_BITS)) begin
                cfg_shift <= {cfg_shift[6:0], link.serial_config_in};
                if (rise_count == 5'(macs_pkg::CFG_BITS - 1)) begin
                    cfg_word <= {cfg_shift[6:0], link.serial_config_in};
                    cfg_toggle <= ~cfg_toggle;
                end
            end
            // Wrap after a whole frame so the next frame is captured again
            if (rise_count == 5'(macs_pkg::RESULT_BITS - 1)) begin
                rise_count <= 5'h00;
            end else begin
                rise_count <= rise_count + 5'h01;
            end
        end
    end
    // ****************************************
    // Link side: output shift on falling edges
    // ****************************************
    logic [15:0] out_shift;
    logic [4:0] fall_count;
    logic acq_toggle;
    logic [15:0] result_hold;
    logic load_toggle;
    logic load_seen;
    always_ff @(negedge link.shift_clock or negedge presetn) begin
        if (!presetn) begin
            out_shift <= macs_pkg::RESULT_RESET;
            fall_count <= 5'h00;
            acq_toggle <= 1'b0;
            load_seen <= 1'b0;
        end else begin
            if (load_seen != load_toggle) begin
                // First fall after a new result: reload then shift
                load_seen <= load_toggle;
                out_shift <= {result_hold[14:0], 1'b0};
                fall_count <= 5'h01;
            end else begin
                out_shift <= {out_shift[14:0], 1'b0};
                fall_count <= fall_count + 5'h01;
            end
            if (fall_count == 5'(macs_pkg::ACQ_EDGE - 1)) begin
                acq_toggle <= ~acq_toggle;
            end
        end
    end
    // ****************************************
    // Link side: result pin
    // ****************************************
    // Before first fall the loaded MSB must already show
    logic msb_pending;
    assign msb_pending = load_seen != load_toggle;
    assign link.serial_result_out = msb_pending ? result_hold[15] :
        out_shift[15];
    // ****************************************
    // Core side: synchronisers
    // ****************************************
    logic [1:0] start_sync;
    logic [2:0] acq_sync;
    logic [2:0] cfg_sync;
    logic start_prev;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            start_sync <= 2'b00;
            acq_sync <= 3'b000;
            cfg_sync <= 3'b000;
            start_prev <= 1'b0;
        end else begin
            start_sync <= {start_sync[0], link.conversion_start};
            acq_sync <= {acq_sync[1:0], acq_toggle};
            cfg_sync <= {cfg_sync[1:0], cfg_toggle};
            start_prev <= start_sync[1];
        end
    end
    // A change of a synchronised toggle marks one event of the link side
    function automatic logic toggled(input logic [2:0] pipe);
        return pipe[2] != pipe[1];
    endfunction
    // Bits beyond the converter width read as zero
    function automatic logic [15:0] narrow_mask(input int width);
        return ~16'((1 << (macs_pkg::RESULT_BITS - width)) - 1);
    endfunction
    logic start_rise;
    assign start_rise = start_sync[1] & ~start_prev;
    // ****************************************
    // Core side: configuration hand-over
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            active_config <= macs_pkg::CFG_RESET;
        end else if (toggled(cfg_sync)) begin
            // Word has stood still two pclk edges before this read
            active_config <= cfg_word;
        end
    end
    // ****************************************
    // Core side: acquisition and conversion
    // ****************************************
    typedef enum logic [1:0] {
        MACS_IDLE = 2'b00,
        MACS_ACQ = 2'b01,
        MACS_CONV = 2'b10
    } macs_state_t;
    macs_state_t state;
    logic [15:0] conv_count;
    logic [15:0] approximation_register;
    logic [4:0] bit_idx;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= MACS_IDLE;
            conv_count <= 16'h0000;
            approximation_register <= macs_pkg::RESULT_RESET;
            bit_idx <= 5'h00;
            link.busy_n <= 1'b1;
            result_hold <= macs_pkg::RESULT_RESET;
            load_toggle <= 1'b0;
            acquiring <= 1'b0;
        end else begin
            unique case (state)
                MACS_IDLE, MACS_ACQ: begin
                    if (toggled(acq_sync)) begin
                        state <= MACS_ACQ;
                        acquiring <= 1'b1;
                    end
                    if (start_rise) begin
                        state <= MACS_CONV;
                        acquiring <= 1'b0;
                        link.busy_n <= 1'b0;
                        conv_count <= 16'h0000;
                        approximation_register <= macs_pkg::RESULT_RESET;
                        // Resolve from bit 15 always; narrow widths masked
                        bit_idx <= 5'(macs_pkg::RESULT_BITS - 1);
                    end
                end
                MACS_CONV: begin
                    // Start edges ignored here
                    conv_count <= conv_count + 16'h0001;
                    if (bit_idx != 5'h1f) begin
                        approximation_register[bit_idx[3:0]] <= analog_code[bit_idx[3:0]];
                        bit_idx <= bit_idx - 5'h01;
                    end
                    if (conv_count == 16'(CONV_CYC - 1)) begin
                        state <= MACS_IDLE;
                        link.busy_n <= 1'b1;
                        // Code is already offset or two's complement
                        result_hold <= approximation_register & narrow_mask(RES_BITS);
                        load_toggle <= ~load_toggle;
                    end
                end
                default: state <= MACS_IDLE;
            endcase
        end
    end
    // ****************************************
    // Output driver enable
    // ****************************************
    // Tied mode: read stays high with start, so the pin floats while
    // converting; with read held low the driver never lets go
    assign link.result_out_oe_n = link.read_enable_n;
endmodule
`default_nettype wire

/* core/macs_host.sv */
// Host end: APB command registers driving the serial link
`timescale 1ns/1ps
`default_nettype none
module macs_host (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    macs_link_if.host link
);
    // ****************************************
    // Registers
    // ****************************************
    logic [7:0] cfg_reg;
    logic tied_mode;
    logic go;
    logic done;
    logic [15:0] result;
    logic [15:0] rx;
    logic [1:0] busy_sync;
    logic [1:0] data_sync;
    typedef enum logic [2:0] {
        MACS_H_IDLE = 3'b000,
        MACS_H_SHIFT = 3'b001,
        MACS_H_ACQ = 3'b010,
        MACS_H_START = 3'b011,
        MACS_H_WAIT = 3'b100
    } macs_hstate_t;
    macs_hstate_t state;
    logic [4:0] edge_count;
    logic [15:0] timer;
    logic [7:0] tx;
    logic div;
    logic access;
    assign access = psel & penable;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_sync <= 2'b11;
            data_sync <= 2'b11;
        end else begin
            busy_sync <= {busy_sync[0], link.busy_n};
            data_sync <= {data_sync[0], link.result_wire};
        end
    end
    // ****************************************
    // APB slave, zero wait states
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
            cfg_reg <= macs_pkg::CFG_RESET;
            tied_mode <= 1'b0;
        end else begin
            pready <= psel & ~penable;
            pslverr <= 1'b0;
            if (psel & ~penable) begin
                prdata <= 32'h00000000;
                pslverr <= !(paddr == macs_pkg::REG_CTRL ||
                    paddr == macs_pkg::REG_STATUS ||
                    paddr == macs_pkg::REG_RESULT);
                unique case (paddr)
                    macs_pkg::REG_CTRL:
                        prdata <= {22'h000000, tied_mode, 1'b0, cfg_reg};
                    macs_pkg::REG_STATUS:
                        prdata <= {30'h00000000, done, state != MACS_H_IDLE};
                    macs_pkg::REG_RESULT: prdata <= {16'h0000, result};
                    default: prdata <= 32'h00000000;
                endcase
            end
            if (access & pready & pwrite & paddr == macs_pkg::REG_CTRL) begin
                cfg_reg <= pwdata[7:0];
                tied_mode <= pwdata[macs_pkg::CTRL_TIED_POS];
            end
        end
    end
    assign go = access & pready & pwrite & paddr == macs_pkg::REG_CTRL &
        pwdata[macs_pkg::CTRL_GO_POS];
    // ****************************************
    // Link sequencer
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= MACS_H_IDLE;
            edge_count <= 5'h00;
            timer <= 16'h0000;
            tx <= macs_pkg::CFG_RESET;
            rx <= macs_pkg::RESULT_RESET;
            result <= macs_pkg::RESULT_RESET;
            done <= 1'b0;
            div <= 1'b0;
            link.shift_clock <= 1'b0;
            link.serial_config_in <= 1'b0;
            link.conversion_start <= 1'b0;
            link.read_enable_n <= 1'b1;
        end else begin
            unique case (state)
                MACS_H_IDLE: begin
                    if (go & busy_sync[1]) begin
                        state <= MACS_H_SHIFT;
                        tx <= {pwdata[6:0], 1'b0};
                        link.serial_config_in <= pwdata[7];
                        link.read_enable_n <= 1'b0;
                        link.conversion_start <= 1'b0;
                        edge_count <= 5'h00;
                        div <= 1'b0;
                        done <= 1'b0;
                    end
                end
                MACS_H_SHIFT: begin
                    div <= ~div;
                    if (div) begin
                        link.shift_clock <= ~link.shift_clock;
                        if (link.shift_clock) begin
                            // Two-flop view lags the pin by two pclk, so the
                            // value seen at the fall is the one at the rise
                            rx <= {rx[14:0], data_sync[1]};
                            edge_count <= edge_count + 5'h01;
                            link.serial_config_in <= tx[7];
                            tx <= {tx[6:0], 1'b0};
                            if (edge_count == 5'(macs_pkg::RESULT_BITS - 1)) begin
                                state <= MACS_H_ACQ;
                                timer <= 16'h0000;
                            end
                        end
                    end
                end
                MACS_H_ACQ: begin
                    timer <= timer + 16'h0001;
                    if (timer == 16'(macs_pkg::ACQ_CYCLES)) begin
                        state <= MACS_H_START;
                        timer <= 16'h0000;
                        link.conversion_start <= 1'b1;
                        if (tied_mode) link.read_enable_n <= 1'b1;
                    end
                end
                MACS_H_START: begin
                    timer <= timer + 16'h0001;
                    if (timer == 16'(macs_pkg::START_HIGH_CYCLES)) begin
                        state <= MACS_H_WAIT;
                        result <= rx;
                        if (!tied_mode) link.conversion_start <= 1'b0;
                    end
                end
                MACS_H_WAIT: begin
                    if (busy_sync[1] & timer > 16'h0008) begin
                        state <= MACS_H_IDLE;
                        done <= 1'b1;
                        link.conversion_start <= 1'b0;
                        link.read_enable_n <= 1'b0;
                    end
                    timer <= timer + 16'h0001;
                end
                default: state <= MACS_H_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

/* include/macs_link_if.sv */
// Three-wire serial link plus conversion start, busy and read enable
`timescale 1ns/1ps
`default_nettype none
interface macs_link_if;
    logic shift_clock;
    logic serial_config_in;
    logic serial_result_out;
    logic result_out_oe_n;
    logic conversion_start;
    logic read_enable_n;
    logic busy_n;
    wire logic result_wire;
    assign result_wire = result_out_oe_n ? 1'b1 : serial_result_out;
    modport device (
        input shift_clock,
        input serial_config_in,
        output serial_result_out,
        output result_out_oe_n,
        input conversion_start,
        input read_enable_n,
        output busy_n
    );
    modport host (
        output shift_clock,
        output serial_config_in,
        input result_wire,
        output conversion_start,
        output read_enable_n,
        input busy_n
    );
endinterface
`default_nettype wire

/* include/macs_pkg.sv */
// Shared constants of the converter serial control link
package macs_pkg;
    // ****************************************
    // Word sizes
    // ****************************************
    localparam int CFG_BITS = 8;
    localparam int RESULT_BITS = 16;
    localparam int ACQ_EDGE = 6;
    localparam int ZERO_BITS_12 = 4;
    localparam int ZERO_BITS_14 = 2;
    // ****************************************
    // Configuration word field positions, first shifted bit is bit 7
    // ****************************************
    localparam int CFG_SGL_POS = 7;
    localparam int CFG_ODD_POS = 6;
    localparam int CFG_SEL1_POS = 5;
    localparam int CFG_SEL0_POS = 4;
    localparam int CFG_UNI_POS = 3;
    localparam int CFG_GAIN_POS = 2;
    localparam int CFG_NAP_POS = 1;
    localparam int CFG_SLEEP_POS = 0;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [15:0] RESULT_RESET = 16'h0000;
    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_NS = 20;
    localparam int CONV_NS = 4000;
    localparam int CONV_CYCLES = CONV_NS / CLK_NS;
    localparam int ACQ_NS = 4000;
    localparam int ACQ_CYCLES = (ACQ_NS + CLK_NS - 1) / CLK_NS;
    localparam int START_HIGH_NS = 40;
    localparam int START_HIGH_CYCLES = (START_HIGH_NS + CLK_NS - 1) / CLK_NS;
    localparam int LINK_DIV = 2;
    // ****************************************
    // Host command registers, APB byte addresses
    // ****************************************
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_RESULT = 8'h08;
    localparam logic [7:0] REG_SAMPLE = 8'h0c;
    localparam int CTRL_GO_POS = 8;
    localparam int CTRL_TIED_POS = 9;
    localparam int STAT_BUSY_POS = 0;
    localparam int STAT_DONE_POS = 1;
endpackage
